// File: pkg/rsb_pkg.sv
// constants and types of the rfid to spi master bridge
package rsb_pkg;
    // ****************************************
    // frame shape on the serial link
    // ****************************************
    localparam int unsigned CMD_BITS  = 16; // single access frame length
    localparam int unsigned BLK_BITS  = 8;  // extra bits per further register
    localparam int unsigned BLK_LOG   = 3;  // log2 of the block length
    localparam int unsigned MAX_REGS  = 6;  // most registers in one multi read
    localparam int unsigned BIT_W     = 6;  // width of the bit counter
    localparam int unsigned IDX_W     = 6;  // slave register index width
    localparam int unsigned BYTE_W    = 8;  // serial register width
    localparam int unsigned WORD_W    = 16; // air interface word width
    localparam int unsigned ADDR_W    = 8;  // air interface word address width
    localparam int unsigned CNT_W     = 8;  // air interface word count width
    localparam int unsigned NREG_W    = 3;  // width of the register count
    // ****************************************
    // command word, sent from bit 15 down to bit 0
    // ****************************************
    localparam int unsigned WIRE_DIR  = 15; // first bit on wire: direction flag
    localparam int unsigned WIRE_MS   = 14; // second bit: multi_read_flag
    localparam int unsigned WIRE_AD   = 8;  // low end of the index field
    localparam logic        DIR_WR    = 1'b0;
    localparam logic        DIR_RD    = 1'b1;
    localparam logic [7:0]  RD_FILL   = 8'hff; // mosi level in read data bits
    localparam logic [7:0]  ZERO_HI   = 8'h00; // upper half of a read word
    // ****************************************
    // timing and mapping defaults
    // ****************************************
    localparam int unsigned SCK_HALF_DEF  = 4;    // link clocks per sck half
    localparam int unsigned DIV_W         = 8;    // width of the sck divider
    localparam logic [7:0]  MAP_BASE_DEF  = 8'h00;
    localparam int unsigned MAP_WORDS_DEF = 64;

    typedef enum logic {RSB_SYS_IDLE, RSB_SYS_WAIT} rsb_sys_st_t;
    typedef enum logic [1:0] {RSB_LNK_IDLE, RSB_LNK_LEAD, RSB_LNK_RUN, RSB_LNK_TAIL} rsb_lnk_st_t;
endpackage

// File: design/rsb_bridge.sv
// rfid to spi master bridge: air interface requests in, mode 3 spi frames out
`timescale 1ns/10ps
module rsb_bridge #(
    parameter logic [7:0]  MAP_BASE  = rsb_pkg::MAP_BASE_DEF,
    parameter int unsigned MAP_WORDS = rsb_pkg::MAP_WORDS_DEF,
    parameter int unsigned SCK_HALF  = rsb_pkg::SCK_HALF_DEF
) (
    input  wire logic                          clk_sys,
    input  wire logic                          resetn,
    input  wire logic                          clk_link,
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire logic                          req_write,
    input  wire logic [rsb_pkg::ADDR_W-1:0]    req_addr,
    input  wire logic [rsb_pkg::CNT_W-1:0]     req_count,
    input  wire logic [rsb_pkg::WORD_W-1:0]    req_wdata,
    output logic                               rsp_valid,
    output logic                               rsp_ok,
    output logic [rsb_pkg::MAX_REGS*rsb_pkg::WORD_W-1:0] rsp_rdata,
    output logic                               spi_cs_n,
    output logic                               spi_sck,
    output logic                               spi_mosi,
    input  wire logic                          spi_miso
);
    // ****************************************
    // system side: request check and command
    // ****************************************
    rsb_pkg::rsb_sys_st_t             sst_q;
    logic                             ready_q;
    logic                             rvalid_q;
    logic                             rok_q;
    logic [rsb_pkg::MAX_REGS*rsb_pkg::WORD_W-1:0] rdata_q;
    logic [rsb_pkg::WORD_W-1:0]       cmd_q;
    logic [rsb_pkg::NREG_W-1:0]       nreg_q;
    logic                             rd_q;
    logic                             req_tgl_q;
    logic                             ack_s1_q;
    logic                             ack_s2_q;
    logic                             ack_s3_q;
    logic                             ack_f_q;
    logic                             ack_evt;
    logic                             accept;
    logic                             in_map;
    logic                             legal;
    logic [rsb_pkg::ADDR_W:0]         end_addr;
    logic [rsb_pkg::ADDR_W:0]         map_end;
    logic [rsb_pkg::WORD_W-1:0]       cmd_d;
    logic [rsb_pkg::BYTE_W-1:0]       byte_q [rsb_pkg::MAX_REGS];
    logic                             done_tgl_q;

    assign accept = req_valid && ready_q;
    assign end_addr = {1'b0, req_addr} + {1'b0, req_count};
    assign map_end = {1'b0, MAP_BASE} + (rsb_pkg::ADDR_W+1)'(MAP_WORDS);

    // address must fall inside the bridge window and the index range
    always_comb
    begin
        in_map = (req_addr >= MAP_BASE) && (end_addr <= map_end)
            && (end_addr <= (rsb_pkg::ADDR_W+1)'(1 << rsb_pkg::IDX_W));
        if (req_write)
            legal = in_map && (req_count == rsb_pkg::CNT_W'(1));
        else
            legal = in_map && (req_count != '0)
                && (req_count <= rsb_pkg::CNT_W'(rsb_pkg::MAX_REGS));
    end

    // build the command frame from the request
    always_comb
    begin
        cmd_d = '0;
        cmd_d[rsb_pkg::WIRE_DIR] = req_write ? rsb_pkg::DIR_WR : rsb_pkg::DIR_RD;
        cmd_d[rsb_pkg::WIRE_MS] = !req_write
            && (req_count != rsb_pkg::CNT_W'(1));
        cmd_d[rsb_pkg::WIRE_AD +: rsb_pkg::IDX_W] = req_addr[rsb_pkg::IDX_W-1:0];
        // only the low half of the word goes out
        cmd_d[rsb_pkg::BYTE_W-1:0] = req_write ? req_wdata[rsb_pkg::BYTE_W-1:0]
            : rsb_pkg::RD_FILL;
    end

    // ack toggle from the link side, three stages
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
            ack_f_q <= 1'b0;
        end
        else
        begin
            ack_s1_q <= done_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
            if (ack_s2_q == ack_s3_q)
                ack_f_q <= ack_s3_q;
        end
    end

    assign ack_evt = (ack_s2_q == ack_s3_q) && (ack_s3_q != ack_f_q);

    // request state, command hold and handshake
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sst_q <= rsb_pkg::RSB_SYS_IDLE;
            ready_q <= 1'b0;
            cmd_q <= '0;
            nreg_q <= '0;
            rd_q <= 1'b0;
            req_tgl_q <= 1'b0;
        end
        else
        begin
            unique case (sst_q)
                rsb_pkg::RSB_SYS_IDLE:
                begin
                    ready_q <= !(accept && legal);
                    if (accept && legal)
                    begin
                        cmd_q <= cmd_d;
                        nreg_q <= rsb_pkg::NREG_W'(req_count);
                        rd_q <= !req_write;
                        req_tgl_q <= !req_tgl_q;
                        sst_q <= rsb_pkg::RSB_SYS_WAIT;
                    end
                end
                rsb_pkg::RSB_SYS_WAIT:
                begin
                    if (ack_evt)
                    begin
                        ready_q <= 1'b1;
                        sst_q <= rsb_pkg::RSB_SYS_IDLE;
                    end
                end
            endcase
        end
    end

    // reply strobe: after the frame has closed, or at once when refused
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rvalid_q <= 1'b0;
            rok_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= 1'b0;
            if (sst_q == rsb_pkg::RSB_SYS_IDLE && accept && !legal)
            begin
                rvalid_q <= 1'b1;
                rok_q <= 1'b0;
            end
            else if (sst_q == rsb_pkg::RSB_SYS_WAIT && ack_evt)
            begin
                rvalid_q <= 1'b1;
                rok_q <= 1'b1;
            end
        end
    end

    // read words, byte right aligned, upper half zero
    for (genvar i = 0; i < rsb_pkg::MAX_REGS; i++)
    begin : g_word
        always_ff @(posedge clk_sys or negedge resetn)
        begin
            if (!resetn)
            begin
                rdata_q[i*rsb_pkg::WORD_W +: rsb_pkg::WORD_W] <= '0;
            end
            else if (sst_q == rsb_pkg::RSB_SYS_WAIT && ack_evt)
            begin
                if (rd_q && (i < int'(nreg_q)))
                begin
                    rdata_q[i*rsb_pkg::WORD_W +: rsb_pkg::WORD_W] <=
                        {rsb_pkg::ZERO_HI, byte_q[i]};
                end
                else
                begin
                    rdata_q[i*rsb_pkg::WORD_W +: rsb_pkg::WORD_W] <= '0;
                end
            end
        end
    end

    assign req_ready = ready_q;
    assign rsp_valid = rvalid_q;
    assign rsp_ok = rok_q;
    assign rsp_rdata = rdata_q;

    // ****************************************
    // link side: sck divider and frame engine
    // ****************************************
    rsb_pkg::rsb_lnk_st_t             lst_q;
    logic [rsb_pkg::DIV_W-1:0]        div_q;
    logic                             tick;
    logic                             sck_q;
    logic                             cs_n_q;
    logic                             mosi_q;
    logic [rsb_pkg::WORD_W-1:0]       tx_q;
    logic [rsb_pkg::BIT_W-1:0]        bit_q;
    logic [rsb_pkg::BIT_W-1:0]        last_q;
    logic [rsb_pkg::BYTE_W-1:0]       rx_q;
    logic                             cap;
    logic                             rq_s1_q;
    logic                             rq_s2_q;
    logic                             rq_s3_q;
    logic                             rq_f_q;
    logic                             start;
    logic                             mi_s1_q;
    logic                             mi_s2_q;
    logic                             mi_s3_q;
    logic                             mi_f_q;

    // request toggle from the system side, three stages
    always_ff @(posedge clk_link or negedge resetn)
    begin
        if (!resetn)
        begin
            rq_s1_q <= 1'b0;
            rq_s2_q <= 1'b0;
            rq_s3_q <= 1'b0;
            rq_f_q <= 1'b0;
        end
        else
        begin
            rq_s1_q <= req_tgl_q;
            rq_s2_q <= rq_s1_q;
            rq_s3_q <= rq_s2_q;
            if (rq_s2_q == rq_s3_q)
                rq_f_q <= rq_s3_q;
        end
    end

    assign start = (rq_s2_q == rq_s3_q) && (rq_s3_q != rq_f_q);

    // miso pin filter, change taken when stages two and three agree
    always_ff @(posedge clk_link or negedge resetn)
    begin
        if (!resetn)
        begin
            mi_s1_q <= 1'b1;
            mi_s2_q <= 1'b1;
            mi_s3_q <= 1'b1;
            mi_f_q <= 1'b1;
        end
        else
        begin
            mi_s1_q <= spi_miso;
            mi_s2_q <= mi_s1_q;
            mi_s3_q <= mi_s2_q;
            if (mi_s2_q == mi_s3_q)
                mi_f_q <= mi_s3_q;
        end
    end

    // half period divider, runs only inside a frame
    always_ff @(posedge clk_link or negedge resetn)
    begin
        if (!resetn)
            div_q <= '0;
        else if (lst_q == rsb_pkg::RSB_LNK_IDLE || tick)
            div_q <= '0;
        else
            div_q <= div_q + rsb_pkg::DIV_W'(1);
    end

    assign tick = (div_q == rsb_pkg::DIV_W'(SCK_HALF - 1));
    // end of a high phase, just before the next falling edge or, on the last bit, the tail
    assign cap = (lst_q == rsb_pkg::RSB_LNK_RUN) && tick && sck_q;

    // frame sequencer: cs, sck and mosi
    always_ff @(posedge clk_link or negedge resetn)
    begin
        if (!resetn)
        begin
            lst_q <= rsb_pkg::RSB_LNK_IDLE;
            sck_q <= 1'b1;
            cs_n_q <= 1'b1;
            mosi_q <= 1'b1;
            tx_q <= '0;
            bit_q <= '0;
            last_q <= '0;
            done_tgl_q <= 1'b0;
        end
        else
        begin
            unique case (lst_q)
                rsb_pkg::RSB_LNK_IDLE:
                begin
                    if (start)
                    begin
                        cs_n_q <= 1'b0;
                        tx_q <= cmd_q;
                        bit_q <= '0;
                        // 16 bits plus 8 per further register
                        last_q <= rsb_pkg::BIT_W'(rsb_pkg::CMD_BITS - 1
                            + rsb_pkg::BLK_BITS * (int'(nreg_q) - 1));
                        lst_q <= rsb_pkg::RSB_LNK_LEAD;
                    end
                end
                rsb_pkg::RSB_LNK_LEAD:
                begin
                    if (tick)
                    begin
                        sck_q <= 1'b0;
                        mosi_q <= tx_q[rsb_pkg::WORD_W-1];
                        tx_q <= {tx_q[rsb_pkg::WORD_W-2:0], 1'b1};
                        lst_q <= rsb_pkg::RSB_LNK_RUN;
                    end
                end
                rsb_pkg::RSB_LNK_RUN:
                begin
                    if (tick && !sck_q)
                        sck_q <= 1'b1;
                    else if (tick && bit_q == last_q)
                        lst_q <= rsb_pkg::RSB_LNK_TAIL;
                    else if (tick)
                    begin
                        sck_q <= 1'b0;
                        mosi_q <= tx_q[rsb_pkg::WORD_W-1];
                        tx_q <= {tx_q[rsb_pkg::WORD_W-2:0], 1'b1};
                        bit_q <= bit_q + rsb_pkg::BIT_W'(1);
                    end
                end
                rsb_pkg::RSB_LNK_TAIL:
                begin
                    if (tick)
                    begin
                        cs_n_q <= 1'b1;
                        mosi_q <= 1'b1;
                        sck_q <= 1'b1;
                        done_tgl_q <= !done_tgl_q;
                        lst_q <= rsb_pkg::RSB_LNK_IDLE;
                    end
                end
            endcase
        end
    end

    // shift in data bits, msb first
    always_ff @(posedge clk_link or negedge resetn)
    begin
        if (!resetn)
            rx_q <= '0;
        else if (cap)
            rx_q <= {rx_q[rsb_pkg::BYTE_W-2:0], mi_f_q};
    end

    // each finished data block lands in its own slot
    for (genvar i = 0; i < rsb_pkg::MAX_REGS; i++)
    begin : g_slot
        always_ff @(posedge clk_link or negedge resetn)
        begin
            if (!resetn)
                byte_q[i] <= '0;
            else if (cap && (bit_q[rsb_pkg::BLK_LOG-1:0] == '1)
                && (int'(bit_q[rsb_pkg::BIT_W-1:rsb_pkg::BLK_LOG]) == i + 1))
                byte_q[i] <= {rx_q[rsb_pkg::BYTE_W-2:0], mi_f_q};
        end
    end

    assign spi_cs_n = cs_n_q;
    assign spi_sck = sck_q;
    assign spi_mosi = mosi_q;
endmodule

// File: tb/rsb_bridge_props.sv
// concurrent checks on the ports of the bridge
`timescale 1ns/10ps
module rsb_bridge_props #(
    parameter int unsigned SCK_HALF = 4
) (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        clk_link,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_write,
    input wire logic [7:0]  req_addr,
    input wire logic [7:0]  req_count,
    input wire logic [15:0] req_wdata,
    input wire logic        rsp_valid,
    input wire logic        rsp_ok,
    input wire logic [95:0] rsp_rdata,
    input wire logic        spi_cs_n,
    input wire logic        spi_sck,
    input wire logic        spi_mosi,
    input wire logic        spi_miso
);
    logic [1:0] pair_q;
    logic [7:0] run_q;
    logic [6:0] rise_q;
    // run length of the cs and sck levels, sck rises per frame
    always_ff @(posedge clk_link or negedge resetn)
        if (!resetn)
        begin
            pair_q <= 2'h3;
            run_q  <= 8'h00;
            rise_q <= 7'h00;
        end
        else
        begin
            pair_q <= {spi_cs_n, spi_sck};
            run_q  <= ({spi_cs_n, spi_sck} != pair_q) ? 8'h01 : run_q + 8'h01;
            rise_q <= spi_cs_n ? 7'h00 : rise_q + 7'(spi_sck & ~pair_q[0]);
        end
    // accepted requests, and the frame start that follows one
    sequence take_bad;
        req_valid && req_ready && !req_write && (req_count == 8'h00 || req_count > 8'h06);
    endsequence
    sequence take_one;
        req_valid && req_ready && !req_write && req_count == 8'h01 && req_addr < 8'h40;
    endsequence
    sequence frame_go;
        !req_ready ##[0:3] !spi_cs_n;
    endsequence
    chk_sck_idle_hi: assert property (@(posedge clk_link) disable iff (!resetn)
        spi_cs_n |-> spi_sck) else $error("sck low outside a frame");
    chk_mosi_idle_hi: assert property (@(posedge clk_link) disable iff (!resetn)
        spi_cs_n |-> spi_mosi) else $error("mosi low outside a frame");
    chk_mosi_on_fall: assert property (@(posedge clk_link) disable iff (!resetn)
        $changed(spi_mosi) |-> $fell(spi_sck) || $rose(spi_cs_n)) else $error("mosi moved");
    chk_sck_half_len: assert property (@(posedge clk_link) disable iff (!resetn)
        !spi_cs_n && $changed(spi_sck) |-> run_q == SCK_HALF) else $error("bad sck half");
    chk_pulse_count: assert property (@(posedge clk_link) disable iff (!resetn)
        $rose(spi_cs_n) |-> rise_q >= 16 && rise_q <= 56 && rise_q[2:0] == 3'h0)
        else $error("bad pulse count");
    chk_reply_late: assert property (@(posedge clk_sys) disable iff (!resetn)
        rsp_valid |-> spi_cs_n && req_ready) else $error("reply during frame");
    chk_busy_ready: assert property (@(posedge clk_sys) disable iff (!resetn)
        !spi_cs_n |-> !req_ready) else $error("ready during frame");
    chk_refuse_now: assert property (@(posedge clk_sys) disable iff (!resetn)
        take_bad |-> ##[1:2] rsp_valid && !rsp_ok) else $error("bad count not refused");
    chk_frame_start: assert property (@(posedge clk_sys) disable iff (!resetn)
        take_one |=> frame_go) else $error("no frame after request");
    chk_read_zero_hi: assert property (@(posedge clk_sys) disable iff (!resetn)
        rsp_valid && rsp_ok |-> (rsp_rdata & {6{16'hff00}}) == 96'h0)
        else $error("upper read byte set");
    chk_rsp_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
        rsp_valid |=> !rsp_valid) else $error("reply longer than a cycle");
endmodule
bind rsb_bridge rsb_bridge_props #(.SCK_HALF(SCK_HALF)) u_props (
    .clk_sys(clk_sys), .resetn(resetn), .clk_link(clk_link),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_count(req_count), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_rdata(rsp_rdata),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso)
);

// File: tb/rsb_slave_model.sv
// behavioural mode 3 spi slave facing the bridge
`timescale 1ns/10ps
module rsb_slave_model (
    input  wire logic spi_cs_n,
    input  wire logic spi_sck,
    input  wire logic spi_mosi,
    output logic      spi_miso
);
    logic [7:0]  mem [64];
    logic [15:0] sreg;
    logic [7:0]  cmd;
    logic [5:0]  idx;
    int          cnt;
    int          nfr;
    int          dly;
    // preset register file, miso starts high
    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 8'hc3 ^ 8'(i * 7);
        cmd = 8'h00;
        cnt = 0;
        nfr = 0;
        dly = 0;
        spi_miso = 1'b1;
    end
    // a frame starts, bit count restarts
    always @(negedge spi_cs_n)
    begin
        cnt = 0;
        nfr = nfr + 1;
    end
    // sample mosi on rising sck, decode command and write data
    always @(posedge spi_sck)
        if (!spi_cs_n)
        begin
            sreg = {sreg[14:0], spi_mosi};
            cnt = cnt + 1;
            if (cnt == 8)
                cmd = sreg[7:0];
            if (cnt == 16 && !cmd[7])
                mem[cmd[5:0]] = sreg[7:0];
        end
    // read bytes out on falling sck, index advances each 8 clocks
    always @(negedge spi_sck)
        if (!spi_cs_n && cmd[7] && cnt >= 8)
        begin
            idx = cmd[5:0] + 6'((cnt - 8) / 8);
            spi_miso <= #(dly) mem[idx][7 - (cnt % 8)];
        end
    // released miso shows the inverse of its last level
    always @(posedge spi_cs_n)
        spi_miso <= #(dly) ~spi_miso;
endmodule

// File: tb/tb_rsb_bridge.sv
// self-checking bench for the rfid to spi bridge
`timescale 1ns/10ps
module tb_rsb_bridge;
    logic        clk_sys = 1'b0;
    logic        clk_link = 1'b0;
    logic        resetn = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [7:0]  req_addr = 8'h00;
    logic [7:0]  req_count = 8'h00;
    logic [15:0] req_wdata = 16'h0000;
    logic        req_ready;
    logic        rsp_valid;
    logic        rsp_ok;
    logic [95:0] rsp_rdata;
    logic        spi_cs_n;
    logic        spi_sck;
    logic        spi_mosi;
    logic        spi_miso;
    logic [7:0]  shadow [64];
    logic        bw [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [7:0]  ba [5] = '{8'h00, 8'h00, 8'h03, 8'h3f, 8'h40};
    logic [7:0]  bc [5] = '{8'h07, 8'h00, 8'h02, 8'h02, 8'h01};
    int          fr;
    int          n_fail = 0;
    int          n_tests = 0;
    // system and link clocks, unrelated in phase
    always #25 clk_sys = ~clk_sys;
    always #3 clk_link = ~clk_link;
    rsb_bridge DUT (
        .clk_sys(clk_sys), .resetn(resetn), .clk_link(clk_link),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_addr(req_addr), .req_count(req_count), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_rdata(rsp_rdata),
        .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso)
    );
    rsb_slave_model slv (
        .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso)
    );
    // compare and count
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // counts, verdict and end of run
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one request, wait for its reply under a bound
    task automatic req(input logic w, input logic [7:0] a, input logic [7:0] c,
                       input logic [15:0] d);
        int i;
        while (req_ready !== 1'b1 || rsp_valid !== 1'b0) // let the last reply pass
        begin
            @(posedge clk_sys);
            #1;
        end
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_count = c;
        req_wdata = d;
        @(posedge clk_sys);
        #1;
        req_valid = 1'b0;
        i = 0;
        while (rsp_valid !== 1'b1 && i < 400)
        begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        chk(rsp_valid, 1);
    endtask
    // read n words, check command, length and returned words
    task automatic rd(input logic [7:0] a, input logic [7:0] n);
        logic [95:0] e;
        e = '0;
        for (int k = 0; k < 6; k++)
            if (k < n)
                e[16*k+:16] = {8'h00, shadow[a+k]};
        req(1'b0, a, n, 16'hffff);
        chk(rsp_ok, 1);
        chk(slv.cmd, {1'b1, n > 8'h01, a[5:0]});
        chk(slv.cnt, 16 + 8 * (n - 1));
        chk(rsp_rdata, e);
    endtask
    // test sequence
    initial
    begin
        for (int i = 0; i < 64; i++)
            shadow[i] = 8'hc3 ^ 8'(i * 7);
        repeat (20) @(posedge clk_sys);
        #1;
        chk({req_ready, rsp_valid, rsp_ok, spi_cs_n, spi_sck, spi_mosi}, 6'h07);
        chk(rsp_rdata, 0);
        resetn = 1'b1;
        $display("test reset done");
        rd(8'h05, 8'h01);
        $display("test single read done");
        slv.dly = 20;
        rd(8'h3a, 8'h06);
        slv.dly = 0;
        rd(8'h3e, 8'h02);
        $display("test multi read done");
        req(1'b1, 8'h09, 8'h01, 16'hc35a);
        shadow[9] = 8'h5a;
        chk(slv.cmd, 8'h09);
        chk(slv.cnt, 16);
        chk(slv.mem[9], 8'h5a);
        chk(rsp_ok, 1);
        chk(rsp_rdata, 0);
        rd(8'h09, 8'h01);
        $display("test write done");
        fr = slv.nfr;
        for (int i = 0; i < 5; i++)
        begin
            req(bw[i], ba[i], bc[i], 16'h0001);
            chk(rsp_ok, 0);
        end
        chk(slv.nfr, fr);
        $display("test refusals done");
        close_out();
    end
    // watchdog against a hung handshake
    initial
    begin
        #500000;
        n_fail++;
        close_out();
    end
endmodule
